//--- hdl/rcaf_pkg.sv
// Package with the register map, field widths and carrier types of the comparator alert flags.
package rcaf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus and field widths.
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int IDX_W     = 8;
	localparam int N_CELL    = 14;
	localparam int N_AUX     = 4;
	localparam int N_EVT     = 3;
	localparam int IDX_LSB   = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_CELL_LOW  = 8'h0f;
	localparam logic [IDX_W-1:0] IDX_AUX_COLD  = 8'h10;
	localparam logic [IDX_W-1:0] IDX_AUX_HOT   = 8'h11;
	localparam logic [IDX_W-1:0] IDX_CELL_EN   = 8'h20;
	localparam logic [IDX_W-1:0] IDX_COLD_EN   = 8'h21;
	localparam logic [IDX_W-1:0] IDX_HOT_EN    = 8'h22;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 8'h23;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 8'h24;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values of the flag, enable and mask registers.
	localparam logic [N_CELL-1:0] CELL_RST  = 14'h0000;
	localparam logic [N_AUX-1:0]  AUX_RST   = 4'h0;
	localparam logic [N_EVT-1:0]  EVT_RST   = 3'h0;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Bit positions of the interrupt events.
	localparam int EVT_CELL = 0;
	localparam int EVT_COLD = 1;
	localparam int EVT_HOT  = 2;

	////////////////////////////////////////////////////////////////////////////////
	// One comparator acquisition result as delivered by the comparator engine.
	typedef struct packed {
		logic [N_CELL-1:0] cell_below;
		logic [N_AUX-1:0]  aux_above;
		logic [N_AUX-1:0]  aux_below;
	} rcaf_cmp_s;

	// One APB request as held by the slave.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [DATA_W-1:0] wdata;
	} rcaf_apb_req_s;

	// Byte address to register index.
	function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[IDX_LSB +: IDX_W];
	endfunction

endpackage

//--- hdl/rcaf_flag_bank.sv
// Bank of comparator alert flags refreshed at every comparator acquisition.
`timescale 1ns/1ps
module rcaf_flag_bank
	import rcaf_pkg::*;
#(
	parameter int W = N_AUX
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         acq_done,
	input  wire logic [W-1:0] cond,
	input  wire logic [W-1:0] enable,
	output logic      [W-1:0] flags_ff,
	output logic              rise_ff
);

	logic [W-1:0] nxt_flags;

	// A flag is the enabled condition of the latest acquisition; it holds in between.
	always_comb begin
		nxt_flags = acq_done ? (cond & enable) : flags_ff; // RULE6 RULE7
	end

	// Flag storage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// One-cycle event when an acquisition raises a flag that was clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_ff <= 1'b0;
		end else begin
			rise_ff <= |(nxt_flags & ~flags_ff);
		end
	end

endmodule

//--- hdl/rcaf_irq_ctrl.sv
// Sticky interrupt status with write-one-to-clear, a mask and one level output.
`timescale 1ns/1ps
module rcaf_irq_ctrl
	import rcaf_pkg::*;
#(
	parameter int N = N_EVT
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [N-1:0] events,
	input  wire logic         clr_we,
	input  wire logic         mask_we,
	input  wire logic [N-1:0] wdata,
	output logic      [N-1:0] status_ff,
	output logic      [N-1:0] mask_ff,
	output logic              irq_ff
);

	logic [N-1:0] nxt_status;
	logic [N-1:0] nxt_mask;

	// A new event wins over a clear written in the same cycle.
	always_comb begin
		nxt_status = (status_ff & ~(clr_we ? wdata : '0)) | events;
		nxt_mask   = mask_we ? wdata : mask_ff;
	end

	// Status and mask storage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= '0;
			mask_ff   <= '0;
		end else begin
			status_ff <= nxt_status;
			mask_ff   <= nxt_mask;
		end
	end

	// Level interrupt follows the next status so it never lags the stored bits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_status & nxt_mask);
		end
	end

endmodule

//--- hdl/rcaf_alert_regs.sv
// Redundant comparator alert flag registers with their APB slave and interrupt.
//
// Behaviour
// RULE1 - Aux cold flags readable at index 0x10.
// RULE2 - Cold flag means aux input above threshold.
// RULE3 - Aux hot flags readable at index 0x11.
// RULE4 - Hot flag means aux input below threshold.
// RULE5 - Cell low flags readable at index 0x0F.
// RULE6 - Flag evaluated only when its enable set.
// RULE7 - Flag held until next acquisition clears it.
// RULE8 - Reads harmless, writes ignored, unused bits zero.
`timescale 1ns/1ps
module rcaf_alert_regs
	import rcaf_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              acq_done,
	input  wire rcaf_cmp_s         cmp_sample,
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	rcaf_apb_req_s     req;
	logic [IDX_W-1:0]  req_idx;
	logic              setup_cyc;
	logic              wr_done;
	logic [DATA_W-1:0] nxt_prdata;
	logic              nxt_pslverr;
	logic [DATA_W-1:0] prdata_ff;
	logic              pready_ff;
	logic              pslverr_ff;
	logic [N_CELL-1:0] cell_en_ff;
	logic [N_AUX-1:0]  cold_en_ff;
	logic [N_AUX-1:0]  hot_en_ff;
	logic [N_CELL-1:0] cell_flags;
	logic [N_AUX-1:0]  cold_flags;
	logic [N_AUX-1:0]  hot_flags;
	logic [N_EVT-1:0]  events;
	logic [N_EVT-1:0]  irq_status;
	logic [N_EVT-1:0]  irq_mask;
	logic              irq_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// True when the index names a register of this block.
	function automatic logic is_mapped(input logic [IDX_W-1:0] i);
		case (i)
			IDX_CELL_LOW, IDX_AUX_COLD, IDX_AUX_HOT,
			IDX_CELL_EN, IDX_COLD_EN, IDX_HOT_EN,
			IDX_IRQ_STAT, IDX_IRQ_MASK: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = 1'b0;
			end
		endcase
	endfunction

	// Zero-extends a flag field into a bus word so unused bits read as zero.
	function automatic logic [DATA_W-1:0] widen(input logic [N_CELL-1:0] v);
		widen = {{(DATA_W-N_CELL){1'b0}}, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB request decode.

	// Request fields and phase qualifiers.
	assign req       = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign req_idx   = idx_of(req.addr);
	assign setup_cyc = psel && !penable;
	assign wr_done   = psel && penable && pready_ff && req.write;

	// Read data and error are prepared in the setup cycle for the access cycle.
	always_comb begin
		nxt_prdata  = WORD_ZERO;
		nxt_pslverr = 1'b0;
		if (setup_cyc) begin
			nxt_pslverr = !is_mapped(req_idx);
			if (!req.write) begin
				case (req_idx)
					IDX_CELL_LOW: begin
						nxt_prdata = widen(cell_flags); // RULE5
					end
					IDX_AUX_COLD: begin
						nxt_prdata = widen({{(N_CELL-N_AUX){1'b0}}, cold_flags}); // RULE1
					end
					IDX_AUX_HOT: begin
						nxt_prdata = widen({{(N_CELL-N_AUX){1'b0}}, hot_flags}); // RULE3
					end
					IDX_CELL_EN: begin
						nxt_prdata = widen(cell_en_ff);
					end
					IDX_COLD_EN: begin
						nxt_prdata = widen({{(N_CELL-N_AUX){1'b0}}, cold_en_ff});
					end
					IDX_HOT_EN: begin
						nxt_prdata = widen({{(N_CELL-N_AUX){1'b0}}, hot_en_ff});
					end
					IDX_IRQ_STAT: begin
						nxt_prdata = {{(DATA_W-N_EVT){1'b0}}, irq_status};
					end
					IDX_IRQ_MASK: begin
						nxt_prdata = {{(DATA_W-N_EVT){1'b0}}, irq_mask};
					end
					default: begin
						nxt_prdata = WORD_ZERO;
					end
				endcase
			end
		end
	end

	// Bus answer registers; every access completes in its first access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= WORD_ZERO;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= setup_cyc;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Enable registers; the alert registers themselves take no write.

	// Per-channel alert enables written by software.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_en_ff <= CELL_RST;
			cold_en_ff <= AUX_RST;
			hot_en_ff  <= AUX_RST;
		end else if (wr_done) begin
			case (req_idx)
				IDX_CELL_EN: begin
					cell_en_ff <= req.wdata[N_CELL-1:0];
				end
				IDX_COLD_EN: begin
					cold_en_ff <= req.wdata[N_AUX-1:0];
				end
				IDX_HOT_EN: begin
					hot_en_ff <= req.wdata[N_AUX-1:0];
				end
				default: begin
					cell_en_ff <= cell_en_ff; // RULE8
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flag banks driven by the comparator acquisition.

	// Cell undervoltage flags.
	rcaf_flag_bank #(
		.W (N_CELL)
	) u_cell_bank (
		.pclk     (pclk),
		.presetn  (presetn),
		.acq_done (acq_done),
		.cond     (cmp_sample.cell_below), // RULE5
		.enable   (cell_en_ff),
		.flags_ff (cell_flags),
		.rise_ff  (events[EVT_CELL])
	);

	// Auxiliary above-threshold flags, reported as cold.
	rcaf_flag_bank #(
		.W (N_AUX)
	) u_cold_bank (
		.pclk     (pclk),
		.presetn  (presetn),
		.acq_done (acq_done),
		.cond     (cmp_sample.aux_above), // RULE2
		.enable   (cold_en_ff),
		.flags_ff (cold_flags),
		.rise_ff  (events[EVT_COLD])
	);

	// Auxiliary below-threshold flags, reported as hot.
	rcaf_flag_bank #(
		.W (N_AUX)
	) u_hot_bank (
		.pclk     (pclk),
		.presetn  (presetn),
		.acq_done (acq_done),
		.cond     (cmp_sample.aux_below), // RULE4
		.enable   (hot_en_ff),
		.flags_ff (hot_flags),
		.rise_ff  (events[EVT_HOT])
	);

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt on newly raised alerts.

	// Sticky status, mask and level output.
	rcaf_irq_ctrl #(
		.N (N_EVT)
	) u_irq (
		.pclk      (pclk),
		.presetn   (presetn),
		.events    (events),
		.clr_we    (wr_done && (req_idx == IDX_IRQ_STAT)),
		.mask_we   (wr_done && (req_idx == IDX_IRQ_MASK)),
		.wdata     (req.wdata[N_EVT-1:0]),
		.status_ff (irq_status),
		.mask_ff   (irq_mask),
		.irq_ff    (irq_ff)
	);

	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A completed read of the cold register returns its flags with zero upper bits.
	a_cold_read_data: assert property ( // RULE1
		setup_cyc && !pwrite && idx_of(paddr) == IDX_AUX_COLD
		|=> prdata == {{(DATA_W-N_AUX){1'b0}}, $past(cold_flags)} && pready && !pslverr
	) else $error("cold alert read returned wrong data");

	// Cold flags follow the enabled above-threshold result of the acquisition.
	a_cold_flag_update: assert property ( // RULE2
		acq_done |=> cold_flags == ($past(cmp_sample.aux_above) & $past(cold_en_ff))
	) else $error("cold flags do not match the acquisition");

	// A completed read of the hot register returns its flags with zero upper bits.
	a_hot_read_data: assert property ( // RULE3
		setup_cyc && !pwrite && idx_of(paddr) == IDX_AUX_HOT
		|=> prdata == {{(DATA_W-N_AUX){1'b0}}, $past(hot_flags)} && pready && !pslverr
	) else $error("hot alert read returned wrong data");

	// Hot flags follow the enabled below-threshold result of the acquisition.
	a_hot_flag_update: assert property ( // RULE4
		acq_done |=> hot_flags == ($past(cmp_sample.aux_below) & $past(hot_en_ff))
	) else $error("hot flags do not match the acquisition");

	// Cell flags follow the acquisition and read back at their own index.
	a_cell_flag_update: assert property ( // RULE5
		acq_done |=> cell_flags == ($past(cmp_sample.cell_below) & $past(cell_en_ff))
	) else $error("cell low flags do not match the acquisition");

	a_cell_read_data: assert property ( // RULE5
		setup_cyc && !pwrite && idx_of(paddr) == IDX_CELL_LOW
		|=> prdata == widen($past(cell_flags))
	) else $error("cell alert read returned wrong data");

	// With every enable clear at an acquisition, all flags are clear in the next cycle.
	a_disabled_stays_clear: assert property ( // RULE6
		(cell_en_ff == CELL_RST && cold_en_ff == AUX_RST && hot_en_ff == AUX_RST
			&& acq_done) ##1 (cell_en_ff == CELL_RST)
		|-> cell_flags == CELL_RST && cold_flags == AUX_RST && hot_flags == AUX_RST
	) else $error("flag set while its enable is clear");

	// At an acquisition, every channel whose enable is clear ends up clear.
	a_disabled_bits_clear: assert property ( // RULE6
		acq_done
		|=> (cell_flags & ~$past(cell_en_ff)) == CELL_RST
			&& (cold_flags & ~$past(cold_en_ff)) == AUX_RST
			&& (hot_flags & ~$past(hot_en_ff)) == AUX_RST
	) else $error("disabled channel flag set by an acquisition");

	// After three cycles without an acquisition all flags stand still in the next cycle.
	a_flags_hold: assert property ( // RULE7
		!acq_done [*3]
		|=> $stable(cell_flags) && $stable(cold_flags) && $stable(hot_flags)
	) else $error("alert flags changed without an acquisition");

	// A write to an alert register is answered without error in the next cycle.
	a_ro_write_answer: assert property ( // RULE8
		setup_cyc && pwrite
			&& (idx_of(paddr) == IDX_AUX_COLD || idx_of(paddr) == IDX_AUX_HOT
			|| idx_of(paddr) == IDX_CELL_LOW)
		|=> !pslverr && pready
	) else $error("write to read-only alert register refused");

	// The write lands at the end of the access cycle, so the flags after it must not move.
	a_ro_write_ignored: assert property ( // RULE8
		(setup_cyc && pwrite
			&& (idx_of(paddr) == IDX_AUX_COLD || idx_of(paddr) == IDX_AUX_HOT
			|| idx_of(paddr) == IDX_CELL_LOW)) ##1 !acq_done
		|=> $stable(cold_flags) && $stable(hot_flags) && $stable(cell_flags)
	) else $error("write to read-only alert register took effect");

	// Unmapped addresses answer with an error and zero data.
	a_unmapped_error: assert property ( // RULE8
		setup_cyc && !is_mapped(idx_of(paddr))
		|=> pslverr && pready && prdata == WORD_ZERO
	) else $error("unmapped access not refused");

endmodule

//--- dv/tb_rcaf_alert_regs.sv
// Self-checking testbench of the comparator alert flag registers.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("wrong value %s expected %h seen %h", nm, e, g); \
	end \
end

module tb_rcaf_alert_regs
	import rcaf_pkg::*;
;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              acq_done;
	rcaf_cmp_s         cmp_sample;
	logic              irq;
	logic [DATA_W-1:0] rd;
	logic              err;
	int                errors;
	int                comparisons;
	int                cycles;

	////////////////////////////////////////////////////////////////////////////////
	// Device under test.
	rcaf_alert_regs uut (
		.pclk       (pclk),
		.presetn    (presetn),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.acq_done   (acq_done),
		.cmp_sample (cmp_sample),
		.irq        (irq)
	);

	// Free running 100 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// One APB transfer; the request is held until pready is seen high.
	task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads one register and compares the word and the error flag.
	task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] e, input string nm);
		bus(1'b0, idx, WORD_ZERO);
		`CHK(nm, e, rd)
		`CHK("pslverr", 1'b0, err)
	endtask

	// Presents one acquisition result for a single cycle, then scrambles the sample.
	task automatic acq(input logic [N_CELL-1:0] c, input logic [N_AUX-1:0] a, b);
		@(posedge pclk);
		acq_done   <= 1'b1;
		cmp_sample <= {c, a, b};
		@(posedge pclk);
		acq_done   <= 1'b0;
		cmp_sample <= ~{c, a, b};
		repeat (2) @(posedge pclk);
	endtask

	// Sets all three enable registers.
	task automatic set_en(input logic [N_CELL-1:0] c, input logic [N_AUX-1:0] a, b);
		bus(1'b1, IDX_CELL_EN, {18'h0, c});
		bus(1'b1, IDX_COLD_EN, {28'h0, a});
		bus(1'b1, IDX_HOT_EN, {28'h0, b});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Every register reads zero after reset.
	task automatic t_reset();
		logic [IDX_W-1:0] ids [8];
		ids = '{IDX_CELL_LOW, IDX_AUX_COLD, IDX_AUX_HOT, IDX_CELL_EN, IDX_COLD_EN,
			IDX_HOT_EN, IDX_IRQ_STAT, IDX_IRQ_MASK};
		foreach (ids[i]) rd_chk(ids[i], WORD_ZERO, "reset word");
		acq(14'h3fff, 4'hf, 4'hf);
		rd_chk(IDX_CELL_LOW, WORD_ZERO, "cell disabled");
		rd_chk(IDX_AUX_COLD, WORD_ZERO, "cold disabled");
		rd_chk(IDX_AUX_HOT, WORD_ZERO, "hot disabled");
	endtask

	// Each condition lands in its own register and bit, upper bits zero.
	task automatic t_flags();
		set_en(14'h3fff, 4'hf, 4'hf);
		acq(14'h2a55, 4'h9, 4'h6);
		rd_chk(IDX_CELL_LOW, 32'h0000_2a55, "cell flags");
		rd_chk(IDX_AUX_COLD, 32'h0000_0009, "cold flags");
		rd_chk(IDX_AUX_HOT, 32'h0000_0006, "hot flags");
	endtask

	// Disabled channels stay clear even with the condition present.
	task automatic t_enable();
		set_en(14'h00ff, 4'h3, 4'hc);
		acq(14'h3fff, 4'hf, 4'hf);
		rd_chk(IDX_CELL_LOW, 32'h0000_00ff, "cell enabled");
		rd_chk(IDX_AUX_COLD, 32'h0000_0003, "cold enabled");
		rd_chk(IDX_AUX_HOT, 32'h0000_000c, "hot enabled");
	endtask

	// Flags hold between acquisitions and clear once the fault has gone.
	task automatic t_hold();
		set_en(14'h3fff, 4'hf, 4'hf);
		acq(14'h0001, 4'h1, 4'h2);
		repeat (10) @(posedge pclk);
		rd_chk(IDX_CELL_LOW, 32'h0000_0001, "cell held");
		rd_chk(IDX_AUX_HOT, 32'h0000_0002, "hot held");
		acq(14'h0002, 4'h0, 4'h0);
		rd_chk(IDX_CELL_LOW, 32'h0000_0002, "cell renewed");
		rd_chk(IDX_AUX_COLD, WORD_ZERO, "cold cleared");
		rd_chk(IDX_AUX_HOT, WORD_ZERO, "hot cleared");
	endtask

	// Writes to flag registers are dropped; an unmapped index reports an error.
	task automatic t_ro();
		bus(1'b1, IDX_CELL_LOW, 32'hffff_ffff);
		`CHK("ro pslverr", 1'b0, err)
		bus(1'b1, IDX_AUX_COLD, 32'hffff_ffff);
		bus(1'b1, IDX_AUX_HOT, 32'hffff_ffff);
		rd_chk(IDX_CELL_LOW, 32'h0000_0002, "cell after write");
		rd_chk(IDX_CELL_LOW, 32'h0000_0002, "cell reread");
		rd_chk(IDX_AUX_COLD, WORD_ZERO, "cold after write");
		rd_chk(IDX_AUX_HOT, WORD_ZERO, "hot after write");
		bus(1'b0, 8'h05, WORD_ZERO);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", WORD_ZERO, rd)
	endtask

	// Rising flags set sticky status; mask gates irq; write one clears.
	task automatic t_irq();
		set_en(14'h3fff, 4'hf, 4'hf);
		acq(14'h0000, 4'h0, 4'h0);
		bus(1'b1, IDX_IRQ_STAT, 32'h0000_0007);
		bus(1'b1, IDX_IRQ_MASK, 32'h0000_0007);
		rd_chk(IDX_IRQ_STAT, WORD_ZERO, "status cleared");
		acq(14'h0001, 4'h1, 4'h1);
		rd_chk(IDX_IRQ_STAT, 32'h0000_0007, "status set");
		`CHK("irq on", 1'b1, irq)
		bus(1'b1, IDX_IRQ_MASK, WORD_ZERO);
		repeat (2) @(posedge pclk);
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, IDX_IRQ_STAT, 32'h0000_0005);
		rd_chk(IDX_IRQ_STAT, 32'h0000_0002, "status w1c");
		bus(1'b1, IDX_IRQ_STAT, 32'h0000_0002);
		bus(1'b1, IDX_IRQ_MASK, 32'h0000_0007);
		acq(14'h0001, 4'h1, 4'h1);
		rd_chk(IDX_IRQ_STAT, WORD_ZERO, "no new rise");
		`CHK("irq quiet", 1'b0, irq)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Cuts a hung run short.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			print_verdict();
		end
	end

	// Reset, then the scenarios in turn.
	initial begin
		errors      = 0;
		comparisons = 0;
		cycles      = 0;
		presetn     = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = '0;
		pwdata      = WORD_ZERO;
		acq_done    = 1'b0;
		cmp_sample  = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_flags();
		t_enable();
		t_hold();
		t_ro();
		t_irq();
		print_verdict();
	end
endmodule
